/* File: include/spg_pkg.sv */
package spg_pkg;

    // data path shape: 32-bit word split into 8-bit lanes, one parity bit each
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned LANES     = 4;
    localparam int unsigned LANE_W    = 8;

    // 12 KB array, byte addressed, word indexed internally
    localparam int unsigned ADDR_W    = 14;
    localparam int unsigned WORD_AW   = 12;
    localparam int unsigned DEPTH     = 3072;

    // words kept powered in standby: the lowest 4 KB
    localparam logic [WORD_AW-1:0] RETAIN_WORDS = 12'h400;

    // guard key, key field position and width
    localparam int unsigned        KEY_LSB   = 1;
    localparam int unsigned        KEY_W     = 7;
    localparam logic [KEY_W-1:0]   GUARD_KEY = 7'h78;

    // values after reset
    localparam logic RST_GUARD_EN = 1'b0;
    localparam logic RST_ACTION   = 1'b0;

    // cycles from a taken read to its answer
    localparam int unsigned READ_LAT = 2;

    // error routing choices of the select bit
    typedef enum logic
    {
        ACT_NMI   = 1'b0,
        ACT_RESET = 1'b1
    } spg_action_type;

endpackage : spg_pkg

/* File: rtl/spg_sram_array.sv */
`timescale 1ns/1ps
`default_nettype none

// single-port array with one parity bit stored beside every byte lane
module spg_sram_array
(
    input  wire logic                              clk,
    input  wire logic                              wr_en,
    input  wire logic                              rd_en,
    input  wire logic [spg_pkg::WORD_AW-1:0]       addr,
    input  wire logic [spg_pkg::LANES-1:0]         wr_be,
    input  wire logic [spg_pkg::DATA_W-1:0]        wr_data,
    output var  logic [spg_pkg::DATA_W-1:0]        rd_data,
    output var  logic [spg_pkg::LANES-1:0]         rd_par
);

    genvar g;

    // one storage column per lane; even parity written with each byte
    generate
        for (g = 0; g < spg_pkg::LANES; g++)
        begin : g_lane
            logic [spg_pkg::LANE_W-1:0] mem_q [spg_pkg::DEPTH];
            logic                       par_q [spg_pkg::DEPTH];
            logic [spg_pkg::LANE_W-1:0] byte_w;

            assign byte_w = wr_data[g*spg_pkg::LANE_W +: spg_pkg::LANE_W];

            // no reset on the array: contents are undefined until written
            always_ff @(posedge clk)
            begin
                if (wr_en && wr_be[g])
                begin
                    mem_q[addr] <= byte_w;
                    par_q[addr] <= ^byte_w;
                end
                if (rd_en)
                begin
                    rd_data[g*spg_pkg::LANE_W +: spg_pkg::LANE_W] <= mem_q[addr];
                    rd_par[g]                                    <= par_q[addr];
                end
            end
        end
    endgenerate

endmodule : spg_sram_array

`default_nettype wire

/* File: rtl/spg_parity_guard.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - every write inside the 12 KB stores one even-parity bit per enabled byte lane
// - every read rechecks the parity of each lane taken from the array (not forwarded lanes) and flags any mismatch
// - select bit one sends a parity error to the reset logic
// - select bit zero sends a parity error out as a non-maskable interrupt
// - a read right after a write is served before the write reaches the array
// - parity errors never request a transfer controller activation
// - the lowest 4 KB stays powered in standby; the rest may switch off
// - a store buffer sits in front; loads to it may return buffered data
// - select bit writable only with guard set; guard needs key 0x78
module spg_parity_guard
(
    input  wire logic                          CLK,
    input  wire logic                          SYS_RST,
    input  wire logic                          REQ,
    input  wire logic                          WE,
    input  wire logic [spg_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic [spg_pkg::LANES-1:0]     BE,
    input  wire logic [spg_pkg::DATA_W-1:0]    WDATA,
    output var  logic [spg_pkg::DATA_W-1:0]    RDATA,
    output var  logic                          RVALID,
    input  wire logic                          GUARD_WR,
    input  wire logic [spg_pkg::KEY_W:0]       GUARD_WDATA,
    input  wire logic                          ACTION_WR,
    input  wire logic                          ACTION_WDATA,
    output var  logic                          GUARD_EN,
    output var  logic                          ERROR_ACTION_SELECT,
    output var  logic                          PARITY_RESET_REQ,
    output var  logic                          PARITY_NMI_REQ,
    output var  logic                          TRANSFER_ACT_REQ,
    input  wire logic                          STANDBY,
    output var  logic                          RETAIN_PWR_EN,
    output var  logic                          UPPER_PWR_EN
);

    // request decode
    logic                           req_rd;
    logic                           req_wr;
    logic [spg_pkg::WORD_AW-1:0]    req_word;
    logic                           req_in_range;

    // store buffer, one entry
    logic                           buf_valid_q, buf_valid_d;
    logic [spg_pkg::WORD_AW-1:0]    buf_addr_q, buf_addr_d;
    logic [spg_pkg::LANES-1:0]      buf_be_q, buf_be_d;
    logic [spg_pkg::DATA_W-1:0]     buf_data_q, buf_data_d;
    logic                           buf_range_q, buf_range_d;
    logic                           commit;

    // array port
    logic                           arr_wr_en;
    logic                           arr_rd_en;
    logic [spg_pkg::WORD_AW-1:0]    arr_addr;
    logic [spg_pkg::DATA_W-1:0]     arr_rd_data;
    logic [spg_pkg::LANES-1:0]      arr_rd_par;

    // read stage between array and answer
    logic                           rd_pend_q, rd_pend_d;
    logic                           rd_range_q, rd_range_d;
    logic [spg_pkg::LANES-1:0]      fwd_be_q, fwd_be_d;
    logic [spg_pkg::DATA_W-1:0]     fwd_data_q, fwd_data_d;
    logic [spg_pkg::DATA_W-1:0]     merged;
    logic [spg_pkg::LANES-1:0]      lane_err;
    logic                           par_err;

    // outputs and control
    logic [spg_pkg::DATA_W-1:0]     rdata_q, rdata_d;
    logic                           rvalid_q, rvalid_d;
    logic                           guard_q, guard_d;
    spg_pkg::spg_action_type        action_q, action_d;
    logic                           rst_req_q, rst_req_d;
    logic                           nmi_req_q, nmi_req_d;
    logic                           upper_pwr_q, upper_pwr_d;
    logic                           retain_q;
    logic                           xfer_q;

    // request decode; words above 12 KB never reach the array and read as zero unless still held in the store buffer
    assign req_rd       = REQ && !WE;
    assign req_wr       = REQ && WE;
    assign req_word     = ADDR[spg_pkg::ADDR_W-1:2];
    assign req_in_range = (req_word < spg_pkg::WORD_AW'(spg_pkg::DEPTH));

    // buffer drains only in cycles without a read, so reads overtake it
    always_comb
    begin
        commit      = buf_valid_q && !req_rd;
        buf_valid_d = buf_valid_q && !commit;
        buf_addr_d  = buf_addr_q;
        buf_be_d    = buf_be_q;
        buf_data_d  = buf_data_q;
        buf_range_d = buf_range_q;
        if (req_wr)
        begin
            buf_valid_d = 1'b1;
            buf_addr_d  = req_word;
            buf_be_d    = BE;
            buf_data_d  = WDATA;
            buf_range_d = req_in_range;
        end
    end

    // array port: the read wins, a pending commit waits
    assign arr_rd_en = req_rd && req_in_range;
    assign arr_wr_en = commit && buf_range_q;
    assign arr_addr  = req_rd ? req_word : buf_addr_q;

    // read stage: snapshot buffer lanes that hit the read address
    always_comb
    begin
        rd_pend_d  = req_rd;
        rd_range_d = req_in_range;
        fwd_data_d = buf_data_q;
        fwd_be_d   = (buf_valid_q && (buf_addr_q == req_word)) ? buf_be_q : '0;
    end

    // per lane merge and parity check; forwarded lanes never hit the array
    generate
        for (genvar g = 0; g < spg_pkg::LANES; g++)
        begin : g_chk
            localparam int unsigned LO = g * spg_pkg::LANE_W;
            logic [spg_pkg::LANE_W-1:0] arr_byte;
            assign arr_byte = rd_range_q ? arr_rd_data[LO +: spg_pkg::LANE_W] : 8'h00;
            assign merged[LO +: spg_pkg::LANE_W] =
                fwd_be_q[g] ? fwd_data_q[LO +: spg_pkg::LANE_W] : arr_byte;
            assign lane_err[g] = rd_range_q && !fwd_be_q[g]
                && ((^arr_rd_data[LO +: spg_pkg::LANE_W]) != arr_rd_par[g]);
        end
    endgenerate

    // answer and error routing by the select bit held at answer time
    always_comb
    begin
        par_err   = rd_pend_q && (|lane_err);
        rvalid_d  = rd_pend_q;
        rdata_d   = rd_pend_q ? merged : rdata_q;
        rst_req_d = par_err && (action_q == spg_pkg::ACT_RESET);
        nmi_req_d = par_err && (action_q == spg_pkg::ACT_NMI);
    end

    // guard and select bit, a bad key leaves the guard unchanged; the retained
    // bank is never switched off, only the upper bank drops in standby
    always_comb
    begin
        guard_d     = guard_q;
        action_d    = action_q;
        upper_pwr_d = !STANDBY;
        if (GUARD_WR && (GUARD_WDATA[spg_pkg::KEY_W:spg_pkg::KEY_LSB] == spg_pkg::GUARD_KEY))
        begin
            guard_d = GUARD_WDATA[0];
        end
        if (ACTION_WR && guard_q)
        begin
            action_d = spg_pkg::spg_action_type'(ACTION_WDATA);
        end
    end

    // all state registers
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            buf_valid_q <= 1'b0;
            buf_addr_q  <= '0;
            buf_be_q    <= '0;
            buf_data_q  <= '0;
            buf_range_q <= 1'b0;
            rd_pend_q   <= 1'b0;
            rd_range_q  <= 1'b0;
            fwd_be_q    <= '0;
            fwd_data_q  <= '0;
            rdata_q     <= '0;
            rvalid_q    <= 1'b0;
            guard_q     <= spg_pkg::RST_GUARD_EN;
            action_q    <= spg_pkg::spg_action_type'(spg_pkg::RST_ACTION);
            rst_req_q   <= 1'b0;
            nmi_req_q   <= 1'b0;
            upper_pwr_q <= 1'b1;
            retain_q    <= 1'b1;
            xfer_q      <= 1'b0;
        end
        else
        begin
            buf_valid_q <= buf_valid_d;
            buf_addr_q  <= buf_addr_d;
            buf_be_q    <= buf_be_d;
            buf_data_q  <= buf_data_d;
            buf_range_q <= buf_range_d;
            rd_pend_q   <= rd_pend_d;
            rd_range_q  <= rd_range_d;
            fwd_be_q    <= fwd_be_d;
            fwd_data_q  <= fwd_data_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            guard_q     <= guard_d;
            action_q    <= action_d;
            rst_req_q   <= rst_req_d;
            nmi_req_q   <= nmi_req_d;
            upper_pwr_q <= upper_pwr_d;
            retain_q    <= 1'b1;
            xfer_q      <= 1'b0;
        end
    end

    spg_sram_array u_array
    (
        .clk     (CLK),
        .wr_en   (arr_wr_en),
        .rd_en   (arr_rd_en),
        .addr    (arr_addr),
        .wr_be   (buf_be_q),
        .wr_data (buf_data_q),
        .rd_data (arr_rd_data),
        .rd_par  (arr_rd_par)
    );

    // outputs straight from flops
    assign RDATA               = rdata_q;
    assign RVALID              = rvalid_q;
    assign GUARD_EN            = guard_q;
    assign ERROR_ACTION_SELECT = action_q;
    assign PARITY_RESET_REQ    = rst_req_q;
    assign PARITY_NMI_REQ      = nmi_req_q;
    assign TRANSFER_ACT_REQ    = xfer_q;
    assign RETAIN_PWR_EN       = retain_q;
    assign UPPER_PWR_EN        = upper_pwr_q;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_full_write_then_read;
        arr_rd_en && $past(arr_wr_en) && ($past(arr_addr) == arr_addr)
            && ($past(buf_be_q) == 4'hf);
    endsequence
    sequence s_read_taken;
        req_rd;
    endsequence
    property p_par_store;
        s_full_write_then_read |=> (lane_err == 4'h0);
    endproperty
    a_par_store: assert property (p_par_store) else $error("stored parity mismatch");
    property p_err_notify;
        par_err |=> (PARITY_RESET_REQ || PARITY_NMI_REQ);
    endproperty
    a_err_notify: assert property (p_err_notify) else $error("parity error not signalled");
    property p_err_reset;
        (par_err && action_q == spg_pkg::ACT_RESET) |=> (PARITY_RESET_REQ && !PARITY_NMI_REQ);
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error not sent to reset");
    property p_err_nmi;
        (par_err && action_q == spg_pkg::ACT_NMI) |=> (PARITY_NMI_REQ && !PARITY_RESET_REQ);
    endproperty
    a_err_nmi: assert property (p_err_nmi) else $error("error not sent as nmi");
    property p_read_first;
        (s_read_taken and buf_valid_q) |-> !arr_wr_en ##1 buf_valid_q;
    endproperty
    a_read_first: assert property (p_read_first) else $error("write overtook read");
    property p_no_xfer;
        ##1 (PARITY_RESET_REQ || PARITY_NMI_REQ) |-> !TRANSFER_ACT_REQ;
    endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("transfer request on parity error");
    property p_standby_pwr;
        STANDBY |=> (!UPPER_PWR_EN && RETAIN_PWR_EN);
    endproperty
    a_standby_pwr: assert property (p_standby_pwr) else $error("standby power wrong");
    property p_fwd;
        (s_read_taken and buf_valid_q && buf_addr_q == req_word && buf_be_q == 4'hf)
            |-> ##2 (RVALID && RDATA == $past(buf_data_q, 2));
    endproperty
    a_fwd: assert property (p_fwd) else $error("buffered data not returned");
    property p_bad_key;
        (GUARD_WR && GUARD_WDATA[7:1] != 7'h78) |=> $stable(guard_q);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("guard changed on bad key");
    property p_locked_select;
        (ACTION_WR && !guard_q) |=> $stable(action_q);
    endproperty
    a_locked_select: assert property (p_locked_select) else $error("select written while locked");
    property p_pulse;
        (PARITY_RESET_REQ || PARITY_NMI_REQ) |-> RVALID;
    endproperty
    a_pulse: assert property (p_pulse) else $error("error without read answer");
    property p_answer;
        s_read_taken |-> ##2 RVALID;
    endproperty
    a_answer: assert property (p_answer) else $error("read answer late");

endmodule : spg_parity_guard

`default_nettype wire

/* File: tb/spg_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// bus master standing in for the cpu side of the access port
module spg_cpu_model
(
    input  wire logic                          clk,
    output var  logic                          req,
    output var  logic                          we,
    output var  logic [spg_pkg::ADDR_W-1:0]    addr,
    output var  logic [spg_pkg::LANES-1:0]     be,
    output var  logic [spg_pkg::DATA_W-1:0]    wdata,
    input  wire logic [spg_pkg::DATA_W-1:0]    rdata,
    input  wire logic                          rvalid
);
    // quiet bus from time zero
    initial
    begin
        req   = 1'b0;
        we    = 1'b0;
        addr  = '0;
        be    = '0;
        wdata = '0;
    end

    // one access per call; lines held so calls may run back to back
    task automatic issue(input logic w, input logic [spg_pkg::ADDR_W-1:0] a,
                         input logic [spg_pkg::LANES-1:0] b,
                         input logic [spg_pkg::DATA_W-1:0] d);
        @(posedge clk);
        req   <= 1'b1;
        we    <= w;
        addr  <= a;
        be    <= b;
        wdata <= d;
    endtask : issue

    // released lines flip so a stale value can never look valid
    task automatic idle();
        @(posedge clk);
        req   <= 1'b0;
        we    <= ~we;
        addr  <= ~addr;
        be    <= ~be;
        wdata <= ~wdata;
    endtask : idle

    // bounded wait for the read answer, taken where it is settled
    task automatic get_answer(output logic [spg_pkg::DATA_W-1:0] d, output logic ok);
        ok = 1'b0;
        d  = '0;
        for (int n = 0; n < 6 && !ok; n++)
        begin
            @(negedge clk);
            if (rvalid === 1'b1)
            begin
                ok = 1'b1;
                d  = rdata;
            end
        end
    endtask : get_answer
endmodule : spg_cpu_model

`default_nettype wire

/* File: tb/tb_spg_parity_guard.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_spg_parity_guard;
    logic        clk;
    logic        sys_rst;
    logic        guard_wr;
    logic [7:0]  guard_wdata;
    logic        action_wr;
    logic        action_wdata;
    logic        standby;
    wire  logic  req;
    wire  logic  we;
    wire  logic [13:0] addr;
    wire  logic [3:0]  be;
    wire  logic [31:0] wdata;
    wire  logic [31:0] rdata;
    wire  logic  rvalid;
    wire  logic  guard_en;
    wire  logic  sel;
    wire  logic  rst_req;
    wire  logic  nmi_req;
    wire  logic  xfer_req;
    wire  logic  retain;
    wire  logic  upper;
    int          errors;
    int          checks_done;
    logic [31:0] mem [0:3];

    spg_parity_guard u_dut (.CLK(clk), .SYS_RST(sys_rst), .REQ(req), .WE(we), .ADDR(addr),
        .BE(be), .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid), .GUARD_WR(guard_wr),
        .GUARD_WDATA(guard_wdata), .ACTION_WR(action_wr), .ACTION_WDATA(action_wdata),
        .GUARD_EN(guard_en), .ERROR_ACTION_SELECT(sel), .PARITY_RESET_REQ(rst_req),
        .PARITY_NMI_REQ(nmi_req), .TRANSFER_ACT_REQ(xfer_req), .STANDBY(standby),
        .RETAIN_PWR_EN(retain), .UPPER_PWR_EN(upper));

    spg_cpu_model u_cpu (.clk(clk), .req(req), .we(we), .addr(addr), .be(be),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

    // 100 MHz
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : check

    // collect one answer; a clean read must raise no error pulse at all
    task automatic answer(input string what, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        u_cpu.get_answer(d, ok);
        if (!ok)
        begin
            $display("FAIL %s expected answer seen none", what);
            errors++;
            give_verdict();
        end
        check(what, exp, d);
        check("error pulses", 32'h0, {29'h0, rst_req, nmi_req, xfer_req});
    endtask : answer

    task automatic read_word(input string what, input logic [13:0] a, input logic [31:0] exp);
        u_cpu.issue(1'b0, a, 4'h0, 32'h0);
        u_cpu.idle();
        answer(what, exp);
    endtask : read_word

    task automatic key_write(input logic [7:0] v, input logic exp);
        @(posedge clk);
        guard_wr    <= 1'b1;
        guard_wdata <= v;
        @(posedge clk);
        guard_wr    <= 1'b0;
        @(negedge clk);
        check("guard enable", {31'h0, exp}, {31'h0, guard_en});
    endtask : key_write

    task automatic sel_write(input logic v, input logic exp);
        @(posedge clk);
        action_wr    <= 1'b1;
        action_wdata <= v;
        @(posedge clk);
        action_wr    <= 1'b0;
        @(negedge clk);
        check("select", {31'h0, exp}, {31'h0, sel});
    endtask : sel_write

    task automatic t_reset();
        @(negedge clk);
        check("reset state", 32'h3,
              {26'h0, rvalid, guard_en, sel, xfer_req, retain, upper});
    endtask : t_reset

    // init writes each followed by a gap, then a merged byte-lane write
    task automatic t_init();
        for (int i = 0; i < 4; i++)
        begin
            mem[i] = 32'h1357_9bdf ^ (32'h0101_0101 * i);
            u_cpu.issue(1'b1, 14'(i * 4), 4'hf, mem[i]);
            u_cpu.idle();
        end
        for (int i = 0; i < 4; i++)
            read_word("init word", 14'((3 - i) * 4), mem[3 - i]);
        u_cpu.issue(1'b1, 14'h0, 4'h5, 32'haa00_cc00);
        u_cpu.idle();
        mem[0] = {mem[0][31:24], 8'h00, mem[0][15:8], 8'h00};
        read_word("lane merge", 14'h0, mem[0]);
    endtask : t_init

    // read straight after a write, to another word and to the same word
    task automatic t_reorder();
        u_cpu.issue(1'b1, 14'h0, 4'hf, 32'hdead_0001);
        u_cpu.issue(1'b0, 14'h4, 4'h0, 32'h0);
        u_cpu.idle();
        answer("read passes write", mem[1]);
        mem[0] = 32'hdead_0001;
        u_cpu.issue(1'b1, 14'h8, 4'hf, 32'hbeef_0002);
        u_cpu.issue(1'b0, 14'h8, 4'h0, 32'h0);
        u_cpu.idle();
        answer("buffered load", 32'hbeef_0002);
        mem[2] = 32'hbeef_0002;
        read_word("array after gap", 14'h8, mem[2]);
        read_word("earlier write", 14'h0, mem[0]);
    endtask : t_reorder

    task automatic t_guard();
        sel_write(1'b1, 1'b0);
        key_write(8'hef, 1'b0);
        key_write(8'hf1, 1'b1);
        sel_write(1'b1, 1'b1);
        key_write(8'hf0, 1'b0);
        sel_write(1'b0, 1'b1);
        read_word("read under reset route", 14'hc, mem[3]);
        key_write(8'hf1, 1'b1);
        sel_write(1'b0, 1'b0);
        read_word("read under nmi route", 14'h4, mem[1]);
    endtask : t_guard

    task automatic t_standby();
        @(posedge clk);
        standby <= 1'b1;
        repeat (2) @(negedge clk);
        check("standby power", 32'h2, {30'h0, retain, upper});
        @(posedge clk);
        standby <= 1'b0;
        repeat (2) @(negedge clk);
        check("wake power", 32'h3, {30'h0, retain, upper});
        read_word("retained word", 14'h8, mem[2]);
        read_word("out of range", 14'h3000, 32'h0);
    endtask : t_standby

    initial
    begin
        errors       = 0;
        checks_done  = 0;
        sys_rst      = 1'b1;
        guard_wr     = 1'b0;
        guard_wdata  = 8'h00;
        action_wr    = 1'b0;
        action_wdata = 1'b0;
        standby      = 1'b0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_init();
        t_reorder();
        t_guard();
        t_standby();
        give_verdict();
    end
endmodule : tb_spg_parity_guard

`default_nettype wire
